/* File: src/cpsbc_pkg.sv */
// package: constants and carrier types of the converter port slot buffer control
// Summary of operation
// - buffer length code selects one to four words
// - pointer advances; at length+1 transfer and wrap
// - every holding-register transfer raises the interrupt
// - pointer returns to first location each frame
// - transmit and receive share one location index
// - enabled transmit slot loads current location, advances
// - slot enables past frame length are ignored
// - disabled transmit slots drive zero or float
// - enabled receive slot stores word, advances pointer
// - slot width equals word size, four to sixteen
// - each received word stored left-justified, unpacked
// - either enable advances shared pointer
// - only in-use locations affect status flags
// - receive full set on transfer, cleared after reads
// - receive overflow on refill before read
// - transmit empty set on transfer, cleared by write
// - transmit underflow when in-use register unwritten
// - status shows currently active time slot
// - loopback routes serial output to serial input
// - underflow sends zeros or last written value
// - frame counted in words by four-bit counter
// - unused low bits zero on receive, ignored transmit
// - interrupt flag is full OR empty
package cpsbc_pkg;
  localparam int          DW           = 16;
  localparam int          AW           = 8;
  localparam int          NLOC         = 4;
  localparam int          NSLOT        = 16;
  // register byte addresses
  localparam logic [7:0]  A_CTL1       = 8'h00;
  localparam logic [7:0]  A_CTL2       = 8'h04;
  localparam logic [7:0]  A_STAT       = 8'h08;
  localparam logic [7:0]  A_TSE        = 8'h0C;
  localparam logic [7:0]  A_RSE        = 8'h10;
  localparam logic [7:0]  A_TXH        = 8'h20;
  localparam logic [7:0]  A_RXH        = 8'h30;
  localparam logic [7:0]  A_HOLD_MASK  = 8'hF3;
  // control one fields
  localparam int          B_EN         = 15;
  localparam int          B_LOOP       = 11;
  localparam int          B_UNDERFLOW_MODE       = 7;
  localparam int          B_IDLE       = 6;
  // control two fields
  localparam int          B_BUFFER_LENGTH_CODE_LO    = 10;
  localparam int          B_FLEN_LO    = 5;
  localparam int          B_WS_LO      = 0;
  // status fields
  localparam int          B_EMPTY      = 0;
  localparam int          B_UNF        = 1;
  localparam int          B_FULL       = 2;
  localparam int          B_OVF        = 3;
  localparam int          B_SLOT_LO    = 7;
  localparam logic [3:0]  WS_MIN       = 4'h3;
  localparam logic [3:0]  WS_RST       = 4'hF;
  localparam logic [3:0]  FLEN_RST     = 4'h0;
  localparam logic [1:0]  BUFFER_LENGTH_CODE_RST     = 2'h0;
  localparam logic [15:0] ZERO16       = 16'h0000;

  typedef struct packed {
    logic enable;
    logic loopback_enable;
    logic underflow_mode;
    logic output_idle_mode;
  } cpsbc_ctl_s;

  localparam cpsbc_ctl_s CTL_RST = '{1'b0, 1'b0, 1'b0, 1'b0};
endpackage : cpsbc_pkg

/* File: src/cpsbc_port.sv */
// module: converter serial port buffer control, slot enables and status
`timescale 1ns/1ns
`default_nettype none
module cpsbc_port (
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire logic [7:0]             addr,
  input  wire logic [15:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [15:0]            rdata,
  input  wire logic                   serial_clk,
  input  wire logic                   frame_sync,
  input  wire logic                   serial_data_in,
  output logic                        serial_data_out,
  output logic                        serial_data_out_oe_n,
  output logic                        port_interrupt_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  cpsbc_pkg::cpsbc_ctl_s ctl_reg;
  logic [1:0]  buffer_length_code;
  logic [3:0]  frame_length_code;
  logic [3:0]  word_size_code;
  logic [15:0] transmit_slot_enables_reg;
  logic [15:0] receive_slot_enables_reg;
  logic [15:0] transmit_holding_reg [cpsbc_pkg::NLOC];
  logic [15:0] receive_holding_reg  [cpsbc_pkg::NLOC];
  logic [15:0] tx_mem_reg           [cpsbc_pkg::NLOC];
  logic [15:0] rx_mem_reg           [cpsbc_pkg::NLOC];
  logic [3:0]  rx_unread_reg, rx_ovf_reg, tx_written_reg, tx_unf_reg, in_use;
  logic        transmit_empty_flag;
  logic [2:0]  sync1_reg, sync2_reg;
  logic        sclk_prev_reg, en_prev_reg;
  logic [3:0]  bit_cnt_reg, frame_counter;
  logic        frame_active_reg, load_pend_reg, slot_tx_reg;
  logic [15:0] shift_in_reg, shift_out_reg;
  logic [1:0]  ptr_reg, ptr_next;
  logic [3:0]  ws_eff;
  logic        sclk_rise, sclk_fall, din, en_rise;
  logic        slot_end, frame_end, slot_in_frame, slot_on, tse_eff, rse_eff;
  logic        len_hit, xfer, xfer_rx, hold_hit, tx_hit, rx_hit;
  logic [1:0]  hold_idx;
  logic [15:0] rx_word, status_word;

  // pin synchronisers: clock, frame sync and data each pass two flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {serial_data_in, frame_sync, serial_clk};
      sync2_reg <= sync1_reg;
      sclk_prev_reg <= sync2_reg[0];
    end
  end

  // link events found from the sampled bit clock
  assign sclk_rise = sync2_reg[0] & ~sclk_prev_reg;
  assign sclk_fall = ~sync2_reg[0] & sclk_prev_reg;
  assign din = ctl_reg.loopback_enable ? serial_data_out : sync2_reg[2];
  assign en_rise = ctl_reg.enable & ~en_prev_reg;
  assign ws_eff = (word_size_code < cpsbc_pkg::WS_MIN) ? cpsbc_pkg::WS_MIN : word_size_code;
  assign slot_in_frame = frame_counter <= frame_length_code;
  assign tse_eff = transmit_slot_enables_reg[frame_counter] & slot_in_frame;
  assign rse_eff = receive_slot_enables_reg[frame_counter] & slot_in_frame;
  assign slot_on = tse_eff | rse_eff;
  assign slot_end = sclk_rise & frame_active_reg & (bit_cnt_reg == ws_eff);
  assign frame_end = slot_end & (frame_counter == frame_length_code);
  assign len_hit = slot_end & slot_on & (ptr_reg == buffer_length_code);
  // left-justify the received word; low unused bits come in as zeros
  assign rx_word = 16'({shift_in_reg[14:0], din} << (4'hF - ws_eff));

  // next pointer: wrap on length, else step on an active slot
  always_comb begin
    ptr_next = ptr_reg;
    if (len_hit)
      ptr_next = 2'h0;
    else if (slot_end & slot_on)
      ptr_next = 2'(ptr_reg + 2'h1);
  end

  // a frame end with data pending transfers too; a coincident wrap counts once
  assign xfer = len_hit | (frame_end & (ptr_next != 2'h0)) | en_rise;
  assign xfer_rx = xfer & ~en_rise;

  // frame and slot counting on the sampled bit clock
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_reg <= 4'h0;
      frame_counter <= 4'h0;
      frame_active_reg <= 1'b0;
      load_pend_reg <= 1'b0;
    end else if (!ctl_reg.enable) begin
      bit_cnt_reg <= 4'h0;
      frame_counter <= 4'h0;
      frame_active_reg <= 1'b0;
      load_pend_reg <= 1'b0;
    end else begin
      load_pend_reg <= 1'b0;
      if (sclk_rise & ~frame_active_reg & sync2_reg[1]) begin
        frame_active_reg <= 1'b1;
        frame_counter <= 4'h0;
        bit_cnt_reg <= 4'h0;
        load_pend_reg <= 1'b1;
      end else if (frame_end) begin
        frame_active_reg <= 1'b0; // waits for the next frame sync
      end else if (slot_end) begin
        frame_counter <= 4'(frame_counter + 4'h1);
        bit_cnt_reg <= 4'h0;
        load_pend_reg <= 1'b1;
      end else if (sclk_rise & frame_active_reg) begin
        bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
      end
    end
  end

  // shared pointer for both directions
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      ptr_reg <= 2'h0;
    else if (!ctl_reg.enable || frame_end)
      ptr_reg <= 2'h0;
    else
      ptr_reg <= ptr_next;
  end

  // shifters; load happens a cycle after the pointer moves, well before the fall
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shift_in_reg <= cpsbc_pkg::ZERO16;
      shift_out_reg <= cpsbc_pkg::ZERO16;
      slot_tx_reg <= 1'b0;
    end else begin
      if (sclk_rise)
        shift_in_reg <= {shift_in_reg[14:0], din};
      if (!ctl_reg.enable || frame_end) begin
        slot_tx_reg <= 1'b0;
      end else if (load_pend_reg) begin
        slot_tx_reg <= tse_eff;
        shift_out_reg <= tse_eff ? tx_mem_reg[ptr_reg] : cpsbc_pkg::ZERO16;
      end else if (sclk_fall & slot_tx_reg) begin
        shift_out_reg <= {shift_out_reg[14:0], 1'b0};
      end
    end
  end

  // serial output pin; idle slots drive zero or release the line
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      serial_data_out <= 1'b0;
      serial_data_out_oe_n <= 1'b0;
    end else if (sclk_fall | ~ctl_reg.enable) begin
      if (slot_tx_reg & ctl_reg.enable) begin
        serial_data_out <= shift_out_reg[15];
        serial_data_out_oe_n <= 1'b0;
      end else begin
        serial_data_out <= 1'b0;
        serial_data_out_oe_n <= ctl_reg.output_idle_mode;
      end
    end
  end

  // register decode
  assign hold_idx = addr[3:2];
  assign hold_hit = (addr & cpsbc_pkg::A_HOLD_MASK) == cpsbc_pkg::A_TXH;
  assign tx_hit = hold_hit & wr;
  assign rx_hit = ((addr & cpsbc_pkg::A_HOLD_MASK) == cpsbc_pkg::A_RXH) & rd;

  // software-written configuration
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_reg <= cpsbc_pkg::CTL_RST;
      buffer_length_code <= cpsbc_pkg::BUFFER_LENGTH_CODE_RST;
      frame_length_code <= cpsbc_pkg::FLEN_RST;
      word_size_code <= cpsbc_pkg::WS_RST;
      transmit_slot_enables_reg <= cpsbc_pkg::ZERO16;
      receive_slot_enables_reg <= cpsbc_pkg::ZERO16;
      en_prev_reg <= 1'b0;
    end else begin
      en_prev_reg <= ctl_reg.enable;
      if (wr) begin
        case (addr)
          cpsbc_pkg::A_CTL1: ctl_reg <= '{wdata[cpsbc_pkg::B_EN], wdata[cpsbc_pkg::B_LOOP],
                                          wdata[cpsbc_pkg::B_UNDERFLOW_MODE], wdata[cpsbc_pkg::B_IDLE]};
          cpsbc_pkg::A_CTL2: begin
            buffer_length_code <= wdata[cpsbc_pkg::B_BUFFER_LENGTH_CODE_LO +: 2];
            frame_length_code <= wdata[cpsbc_pkg::B_FLEN_LO +: 4];
            word_size_code <= wdata[cpsbc_pkg::B_WS_LO +: 4];
          end
          cpsbc_pkg::A_TSE: transmit_slot_enables_reg <= wdata;
          cpsbc_pkg::A_RSE: receive_slot_enables_reg <= wdata;
          default: ;
        endcase
      end
    end
  end

  // per-location buffers and flags
  for (genvar i = 0; i < cpsbc_pkg::NLOC; i++) begin : g_loc
    assign in_use[i] = 2'(i) <= buffer_length_code;

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        transmit_holding_reg[i] <= cpsbc_pkg::ZERO16;
        tx_mem_reg[i] <= cpsbc_pkg::ZERO16;
        tx_written_reg[i] <= 1'b0;
        tx_unf_reg[i] <= 1'b0;
      end else begin
        if (tx_hit && hold_idx == 2'(i))
          transmit_holding_reg[i] <= wdata;
        if (xfer && in_use[i]) begin
          // unwritten: zeros, or the last written value when underflow mode is set
          tx_mem_reg[i] <= (tx_written_reg[i] | ctl_reg.underflow_mode) ?
                           transmit_holding_reg[i] : cpsbc_pkg::ZERO16;
          tx_unf_reg[i] <= ~tx_written_reg[i] & ~en_rise;
          tx_written_reg[i] <= tx_hit && hold_idx == 2'(i); // write in same cycle survives
        end else if (tx_hit && hold_idx == 2'(i)) begin
          tx_written_reg[i] <= 1'b1;
          tx_unf_reg[i] <= 1'b0;
        end
      end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        rx_mem_reg[i] <= cpsbc_pkg::ZERO16;
        receive_holding_reg[i] <= cpsbc_pkg::ZERO16;
        rx_unread_reg[i] <= 1'b0;
        rx_ovf_reg[i] <= 1'b0;
      end else begin
        if (slot_end && rse_eff && ptr_reg == 2'(i))
          rx_mem_reg[i] <= rx_word;
        // refill wins over a read in the same cycle
        if (xfer_rx && in_use[i]) begin
          // the word that closes the buffer lands in memory on this same edge
          receive_holding_reg[i] <= (slot_end && rse_eff && ptr_reg == 2'(i)) ?
                                    rx_word : rx_mem_reg[i];
          rx_unread_reg[i] <= 1'b1;
          rx_ovf_reg[i] <= rx_ovf_reg[i] | (rx_unread_reg[i] & ~(rx_hit && hold_idx == 2'(i)));
        end else if (rx_hit && hold_idx == 2'(i)) begin
          rx_unread_reg[i] <= 1'b0;
          rx_ovf_reg[i] <= 1'b0;
        end
      end
    end
  end

  // transmit empty: set by transfer, cleared by a write to an in-use register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      transmit_empty_flag <= 1'b0;
    else if (!ctl_reg.enable)
      transmit_empty_flag <= 1'b0;
    else if (xfer)
      transmit_empty_flag <= 1'b1;
    else if (tx_hit && in_use[hold_idx])
      transmit_empty_flag <= 1'b0;
  end

  // status word; flags look only at in-use locations
  always_comb begin
    status_word = cpsbc_pkg::ZERO16;
    status_word[cpsbc_pkg::B_EMPTY] = transmit_empty_flag;
    status_word[cpsbc_pkg::B_UNF] = |(tx_unf_reg & in_use);
    status_word[cpsbc_pkg::B_FULL] = |(rx_unread_reg & in_use);
    status_word[cpsbc_pkg::B_OVF] = |(rx_ovf_reg & in_use);
    status_word[cpsbc_pkg::B_SLOT_LO +: 4] = frame_counter;
  end

  // interrupt flag and read data, both registered
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      port_interrupt_flag <= 1'b0;
      rdata <= cpsbc_pkg::ZERO16;
    end else begin
      port_interrupt_flag <= status_word[cpsbc_pkg::B_FULL] | transmit_empty_flag;
      if (rd) begin
        if (hold_hit)
          rdata <= transmit_holding_reg[hold_idx];
        else if ((addr & cpsbc_pkg::A_HOLD_MASK) == cpsbc_pkg::A_RXH)
          rdata <= receive_holding_reg[hold_idx];
        else begin
          case (addr)
            cpsbc_pkg::A_CTL1: rdata <= 16'({ctl_reg.enable, 3'h0, ctl_reg.loopback_enable, 3'h0,
                                              ctl_reg.underflow_mode, ctl_reg.output_idle_mode, 6'h00});
            cpsbc_pkg::A_CTL2: rdata <= 16'({buffer_length_code, 1'b0, frame_length_code, 1'b0,
                                              word_size_code});
            cpsbc_pkg::A_STAT: rdata <= status_word;
            cpsbc_pkg::A_TSE:  rdata <= transmit_slot_enables_reg;
            cpsbc_pkg::A_RSE:  rdata <= receive_slot_enables_reg;
            default:           rdata <= cpsbc_pkg::ZERO16; // unmapped reads zero
          endcase
        end
      end else begin
        rdata <= cpsbc_pkg::ZERO16;
      end
    end
  end

  // checks beside the logic they guard
  sequence s_next_slot_loaded;
    load_pend_reg ##1 (slot_tx_reg == $past(tse_eff));
  endsequence
  sequence s_irq_follows;
    transmit_empty_flag ##1 port_interrupt_flag;
  endsequence

  AST_PTR_IN_LENGTH: assert property (ptr_reg <= buffer_length_code || !frame_active_reg)
    else $error("pointer beyond buffer length");
  AST_WRAP_ON_LENGTH: assert property (len_hit |=> ptr_reg == 2'h0)
    else $error("pointer did not wrap at buffer length");
  AST_IRQ_ON_XFER: assert property (xfer |=> s_irq_follows)
    else $error("transfer raised no interrupt");
  AST_FRAME_RESET: assert property (frame_end |=> ptr_reg == 2'h0 && !frame_active_reg)
    else $error("pointer not reset at frame boundary");
  AST_SLOT_LOAD: assert property (slot_end && !frame_end |=> s_next_slot_loaded)
    else $error("next slot not loaded");
  AST_SLOT_IN_FRAME: assert property (frame_active_reg |-> frame_counter <= frame_length_code)
    else $error("slot beyond frame length");
  AST_IDLE_PIN: assert property (sclk_fall && !slot_tx_reg && ctl_reg.enable |=>
                                 !serial_data_out && serial_data_out_oe_n == ctl_reg.output_idle_mode)
    else $error("idle slot pin state wrong");
  AST_EMPTY_CLEAR: assert property (tx_hit && in_use[hold_idx] && !xfer && ctl_reg.enable |=>
                                    !transmit_empty_flag)
    else $error("empty flag not cleared by write");
  AST_FULL_SET: assert property (xfer_rx |=> status_word[cpsbc_pkg::B_FULL])
    else $error("full flag not set by transfer");
  AST_ONE_XFER: assert property (len_hit && frame_end |=> !xfer [*2])
    else $error("double transfer at frame end");

  // pointer steps on an active slot and stands still on an idle one
  AST_PTR_STEP: assert property (ctl_reg.enable && slot_end && slot_on && !len_hit && !frame_end |=>
                                 ptr_reg == 2'($past(ptr_reg) + 2'h1))
    else $error("pointer did not step on active slot");
  AST_PTR_HOLD: assert property (ctl_reg.enable && slot_end && !slot_on && !frame_end |=>
                                 $stable(ptr_reg))
    else $error("pointer moved on idle slot");

  // slot counter steps once per slot inside a frame
  AST_FRAME_COUNT: assert property (ctl_reg.enable && slot_end && !frame_end |=>
                                    frame_counter == 4'($past(frame_counter) + 4'h1))
    else $error("slot counter did not step");

  // receive path: closing word, unused low bits, overflow
  AST_RX_LAST_WORD: assert property (len_hit && rse_eff && ptr_reg == 2'h1 |=>
                                     receive_holding_reg[1] == $past(rx_word))
    else $error("closing word missed the transfer");
  AST_RX_LOW_ZERO: assert property (slot_end && rse_eff && ptr_reg == 2'h0 |=>
                                    (rx_mem_reg[0] & (16'hFFFF >> ({1'b0, ws_eff} + 5'h01))) == cpsbc_pkg::ZERO16)
    else $error("unused low receive bits not zero");
  AST_OVF_ON_REFILL: assert property (xfer_rx && rx_unread_reg[0] && !(rx_hit && hold_idx == 2'h0) |=>
                                      status_word[cpsbc_pkg::B_OVF])
    else $error("overflow not flagged on refill");

  // transmit path: empty, underflow, and what an underflow sends
  AST_EMPTY_ON_XFER: assert property (xfer && ctl_reg.enable |=> transmit_empty_flag)
    else $error("empty flag not set by transfer");
  AST_UNF_ON_XFER: assert property (xfer && !en_rise && !tx_written_reg[0] |=>
                                    status_word[cpsbc_pkg::B_UNF])
    else $error("underflow not flagged at transfer");
  AST_UNF_CLEAR: assert property (tx_hit && hold_idx == 2'h0 && !xfer |=> !tx_unf_reg[0])
    else $error("underflow not cleared by write");
  AST_ZERO_ON_UNF: assert property (xfer && !tx_written_reg[0] && !ctl_reg.underflow_mode |=>
                                    tx_mem_reg[0] == cpsbc_pkg::ZERO16)
    else $error("underflowed location not zeroed");
  AST_RESEND_ON_UNF: assert property (xfer && !tx_written_reg[0] && ctl_reg.underflow_mode |=>
                                      tx_mem_reg[0] == $past(transmit_holding_reg[0]))
    else $error("underflowed location not resent");
  AST_TX_LOAD: assert property (load_pend_reg && ctl_reg.enable && tse_eff |=>
                                shift_out_reg == $past(tx_mem_reg[ptr_reg]))
    else $error("enabled slot not loaded from buffer");

  // interrupt mirrors full or empty one cycle later
  AST_IRQ_IS_OR: assert property (port_interrupt_flag ==
                                  $past(status_word[cpsbc_pkg::B_FULL] | transmit_empty_flag))
    else $error("interrupt flag is not full or empty");
endmodule : cpsbc_port
`default_nettype wire

/* File: bench/cpsbc_codec.sv */
// partner model: converter on the serial link, makes bit clock and frame sync
`timescale 1ns/1ns
`default_nettype none
module cpsbc_codec (
  output logic      serial_clk,
  output logic      frame_sync,
  output logic      serial_data_in,
  input  wire logic serial_data_out_line
);
  // link idles low with the clock standing still
  initial begin
    serial_clk     = 1'b0;
    frame_sync     = 1'b0;
    serial_data_in = 1'b0;
  end

  // one frame of n bits, msb first; output sampled late in each bit, at the fall
  task automatic run_frame(input logic [15:0] send_bits, input int n, output logic [15:0] got_bits);
    // pins change by non-blocking assignment so a shared edge never races the sampler
    got_bits   = 16'h0000;
    frame_sync <= 1'b1;
    #40;
    for (int k = 0; k <= n; k++) begin
      serial_clk <= 1'b1;
      #40;
      serial_clk <= 1'b0;
      frame_sync <= 1'b0;
      if (k > 0) got_bits[n-k] = serial_data_out_line;
      // after the last bit the line is inverted: never leave a stale value
      if (k < n) serial_data_in <= send_bits[n-1-k];
      else serial_data_in <= ~serial_data_in;
      #40;
    end
  endtask : run_frame
endmodule : cpsbc_codec
`default_nettype wire

/* File: bench/converter_port_slot_buffer_control_bench.sv */
// testbench: slot buffer control driven through registers and a serial link model
`timescale 1ns/1ns
`default_nettype none
module converter_port_slot_buffer_control_bench;
  logic        sys_clk;
  logic        rstn;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  wire         serial_clk;
  wire         frame_sync;
  wire         serial_data_in;
  logic        serial_data_out;
  logic        serial_data_out_oe_n;
  logic        port_interrupt_flag;
  wire         sdo_line;
  int          mismatches;
  int          total_checks;
  int          cycles;
  logic [15:0] got;

  // output enable is low while driving; floating line shows as z
  assign sdo_line = serial_data_out_oe_n ? 1'bz : serial_data_out;

  cpsbc_port dut (
    .sys_clk              (sys_clk),
    .rstn                 (rstn),
    .addr                 (addr),
    .wdata                (wdata),
    .wr                   (wr),
    .rd                   (rd),
    .rdata                (rdata),
    .serial_clk           (serial_clk),
    .frame_sync           (frame_sync),
    .serial_data_in       (serial_data_in),
    .serial_data_out      (serial_data_out),
    .serial_data_out_oe_n (serial_data_out_oe_n),
    .port_interrupt_flag  (port_interrupt_flag)
  );

  cpsbc_codec link (
    .serial_clk           (serial_clk),
    .frame_sync           (frame_sync),
    .serial_data_in       (serial_data_in),
    .serial_data_out_line (sdo_line)
  );

  always #5 sys_clk = ~sys_clk;

  // hang guard, far above the fewer than one thousand cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // bus write: one strobe cycle; leading edge wait keeps strobes apart
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // bus read: data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  // 2 slots of 8 bits, two words per transfer; enable last so holding regs load
  task automatic configure(input logic [15:0] c1, input logic [15:0] transmit_slot_enable, input logic [15:0] receive_slot_enable,
                           input logic [15:0] tx0, input logic [15:0] tx1);
    wr_reg(cpsbc_pkg::A_CTL1, 16'h0000);
    wr_reg(cpsbc_pkg::A_CTL2, 16'h0427);
    wr_reg(cpsbc_pkg::A_TSE, transmit_slot_enable);
    wr_reg(cpsbc_pkg::A_RSE, receive_slot_enable);
    wr_reg(cpsbc_pkg::A_TXH, tx0);
    wr_reg(cpsbc_pkg::A_TXH + 8'h04, tx1);
    wr_reg(cpsbc_pkg::A_CTL1, c1);
    repeat (8) @(posedge sys_clk);
  endtask : configure

  // one frame, then time for sync, transfer and interrupt to land
  task automatic frame(input logic [15:0] send, input logic [15:0] exp_out);
    logic [15:0] out_bits;
    link.run_frame(send, 16, out_bits);
    repeat (10) @(posedge sys_clk);
    chk(out_bits, exp_out);
  endtask : frame

  task automatic status_is(input logic [15:0] mask, input logic [15:0] e);
    rd_reg(cpsbc_pkg::A_STAT, got);
    chk(got & mask, e);
  endtask : status_is

  task automatic test_reset();
    chk(rdata, 16'h0000);
    chk({15'h0000, port_interrupt_flag}, 16'h0000);
    rd_reg(cpsbc_pkg::A_CTL2, got);
    chk(got, 16'h000F);
    status_is(16'hFFFF, 16'h0000);
    wr_reg(8'h44, 16'hFFFF);
    rd_reg(8'h44, got);
    chk(got, 16'h0000);
  endtask : test_reset

  // slot 1 transmit disabled but receive enabled; low tx bits must not leak out
  task automatic test_basic();
    configure(16'h8000, 16'h0001, 16'h0003, 16'hA5FF, 16'h3C00);
    chk({15'h0000, port_interrupt_flag}, 16'h0001);
    status_is(16'h000F, 16'h0001);
    frame(16'h5AC3, 16'hA500);
    status_is(16'h000F, 16'h0007);
    status_is(16'h0780, 16'h0080);
    rd_reg(cpsbc_pkg::A_RXH, got);
    chk(got, 16'h5A00);
    status_is(16'h0004, 16'h0004);
    rd_reg(cpsbc_pkg::A_RXH + 8'h04, got);
    chk(got, 16'hC300);
    status_is(16'h000F, 16'h0003);
    frame(16'h5AC3, 16'h0000);
    status_is(16'h000F, 16'h0007);
    frame(16'h1122, 16'h0000);
    status_is(16'h000F, 16'h000F);
    rd_reg(cpsbc_pkg::A_RXH, got);
    chk(got, 16'h1100);
    rd_reg(cpsbc_pkg::A_RXH + 8'h04, got);
    chk(got, 16'h2200);
    status_is(16'h000C, 16'h0000);
    wr_reg(cpsbc_pkg::A_TXH, 16'h1234);
    repeat (3) @(posedge sys_clk);
    status_is(16'h0001, 16'h0000);
    chk({15'h0000, port_interrupt_flag}, 16'h0000);
  endtask : test_basic

  // loopback with floating idle slots and resend on underflow; pin input is all ones
  task automatic test_loop();
    configure(16'h88C0, 16'h0021, 16'h0003, 16'h96AB, 16'h7700);
    frame(16'hFFFF, 16'h96ZZ);
    rd_reg(cpsbc_pkg::A_RXH, got);
    chk(got, 16'h9600);
    rd_reg(cpsbc_pkg::A_RXH + 8'h04, got);
    chk(got, 16'h0000);
    frame(16'hFFFF, 16'h96ZZ);
    rd_reg(cpsbc_pkg::A_RXH, got);
    chk(got, 16'h9600);
  endtask : test_loop

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // reset held four cycles, then the scenarios in turn
  initial begin
    sys_clk      = 1'b0;
    rstn         = 1'b0;
    addr         = 8'h00;
    wdata        = 16'h0000;
    wr           = 1'b0;
    rd           = 1'b0;
    mismatches   = 0;
    total_checks = 0;
    cycles       = 0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    test_reset();
    test_basic();
    test_loop();
    end_of_test();
  end
endmodule : converter_port_slot_buffer_control_bench
`default_nettype wire
